// ===== dsc_pkg.sv
// Constants, register map and types of the digitizer status, calibration and mode register bank.
// Assumes an APB slave with 32-bit data; every register index is printed as a plain number.
//
// Behaviour
// - A channel overrange, even one sample, sets its sticky flag for the acquisition.
// - One independent overrange flag per channel, bit 0 and bit 1.
// - Overrange status word is read-only at index 20900.
// - Writing index 50020 starts offset autocal; value 0 means all ranges.
// - Autocal results change only working values, never storage, until stored.
// - Writing index 50000 recalls a set; reading returns the last recalled set.
// - The default set is recalled automatically after reset, before any user recall.
// - Writing index 50010 stores working values; reading returns the last stored set.
// - Set value 0 selects the default set, the only set without user sets.
// - Default set is store-protected when user sets exist, else writable.
// - Mode writes with zero or several bits set are rejected with an error.
// - Mode register at index 9500 is read/write and returns the current mode.
// - Index 9501 returns a read-only map of supported modes, same encoding.
// - On-board modes: 1h single shot, 2h segmented, 8h dual rate.
// - Streaming modes: 10h single shot, 20h segmented, 80h dual rate.
// - Streaming modes use all on-board memory as a FIFO toward the host.
// - Segmented capture gives every segment the same programmed length.
// - Dual rate stores trigger segments at full rate, sampling slowly between.
// - On-board modes run at full rate; streaming limited by host transfer rate.

package dsc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices as printed; byte address is four times the index.
    localparam logic [31:0] DSC_IDX_MODE       = 32'h0000_251c;
    localparam logic [31:0] DSC_IDX_MODE_MAP   = 32'h0000_251d;
    localparam logic [31:0] DSC_IDX_OVR        = 32'h0000_51a4;
    localparam logic [31:0] DSC_IDX_RECALL     = 32'h0000_c350;
    localparam logic [31:0] DSC_IDX_STORE      = 32'h0000_c35a;
    localparam logic [31:0] DSC_IDX_AUTOCAL    = 32'h0000_c364;
    localparam logic [31:0] DSC_IDX_CTRL       = 32'h0000_c370;
    localparam logic [31:0] DSC_IDX_STATUS     = 32'h0000_c371;
    localparam int          DSC_ADDR_W         = 18;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode encodings.
    localparam logic [7:0] DSC_MODE_ONB_SINGLE = 8'h01;
    localparam logic [7:0] DSC_MODE_ONB_SEG    = 8'h02;
    localparam logic [7:0] DSC_MODE_ONB_DUAL   = 8'h08;
    localparam logic [7:0] DSC_MODE_STR_SINGLE = 8'h10;
    localparam logic [7:0] DSC_MODE_STR_SEG    = 8'h20;
    localparam logic [7:0] DSC_MODE_STR_DUAL   = 8'h80;
    localparam logic [7:0] DSC_MODE_STREAM_MSK = 8'hf0;
    localparam logic [7:0] DSC_MODE_DUAL_MSK   = 8'h88;
    localparam logic [7:0] DSC_MODE_SEG_MSK    = 8'h22;
    localparam logic [7:0] DSC_MODE_RESET      = 8'h01;
    localparam logic [7:0] DSC_MODE_MAP        = 8'hbb;

    ////////////////////////////////////////////////////////////////////////////////
    // Calibration set values and control/status fields.
    localparam logic [7:0]  DSC_SET_FACTORY    = 8'h00;
    localparam logic [31:0] DSC_ALL_RANGES     = 32'h0000_0000;
    localparam int          DSC_CTRL_RUN       = 0;
    localparam int          DSC_ST_BUSY        = 0;
    localparam int          DSC_ST_MODE_ERR    = 1;
    localparam int          DSC_ST_STORE_ERR   = 2;
    localparam int          DSC_ST_RUN         = 3;
    localparam int          DSC_ST_STREAM      = 4;
    localparam int          DSC_ST_ALLRNG      = 5;
    localparam int          DSC_CAL_W          = 16;
    localparam logic [15:0] DSC_CAL_RESET      = 16'h0000;

    typedef enum logic [2:0] {
        DSC_IDLE    = 3'b000,
        DSC_BOOT    = 3'b001,
        DSC_RECALL  = 3'b010,
        DSC_STORE   = 3'b011,
        DSC_AUTOCAL = 3'b100
    } dsc_state_t;

endpackage : dsc_pkg

// ===== dsc_cal_store.sv
// Nonvolatile calibration storage model: one word per set, one access per cycle.
// Assumes the caller never asks for a read and a write in the same cycle.
`timescale 1ns/1ps

module dsc_cal_store #(
    parameter int SETS  = 4,
    parameter int CAL_W = 16
) (
    input  wire logic                     ref_clk,
    input  wire logic                     rst_b,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    input  wire logic [$clog2(SETS)-1:0]  set_idx,
    input  wire logic [CAL_W-1:0]         wr_data,
    output logic      [CAL_W-1:0]         rd_data,
    output logic                          done
);
    import dsc_pkg::*;

    initial begin
        if (SETS < 2) $error("dsc_cal_store needs at least two sets.");
    end

    logic [CAL_W-1:0] mem_q [SETS];

    // Factory contents are reproduced at reset, standing in for preloaded storage.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < SETS; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wr_en) begin
            mem_q[set_idx] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= '0;
            done    <= 1'b0;
        end else begin
            done <= wr_en | rd_en;
            if (rd_en) begin
                rd_data <= mem_q[set_idx];
            end
        end
    end

endmodule // dsc_cal_store

// ===== dsc_regs.sv
// Register bank: overrange status, calibration recall/store/autocal, operating mode.
// Assumes an APB master on ref_clk and synchronous overrange and acquisition inputs.
//
// The APB register port was decided locally.
`timescale 1ns/1ps

module dsc_regs #(
    parameter int USER_SETS    = 3,
    parameter int AUTOCAL_CYC  = 16
) (
    input  wire logic                          ref_clk,
    input  wire logic                          rst_b,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [dsc_pkg::DSC_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [1:0]                    ovr_in,
    input  wire logic                          acq_start,
    output logic      [7:0]                    mode_q,
    output logic                               stream_en_q,
    output logic                               dual_rate_en_q,
    output logic                               seg_fixed_len_q,
    output logic      [dsc_pkg::DSC_CAL_W-1:0] cal_work_q
);
    import dsc_pkg::*;

    localparam int SETS  = USER_SETS + 1;
    localparam int SET_W = $clog2(SETS);

    initial begin
        if (USER_SETS < 1 && SETS < 2) $error("dsc_regs: USER_SETS must be at least 1 here.");
        if (AUTOCAL_CYC < 1) $error("dsc_regs: AUTOCAL_CYC must be at least 1.");
    end

    function automatic logic [DSC_ADDR_W-1:0] byte_addr(input logic [31:0] idx);
        byte_addr = DSC_ADDR_W'(idx << 2);
    endfunction

    function automatic logic one_hot_ok(input logic [31:0] v);
        one_hot_ok = (v[31:8] == 24'h0000_00) && ($countones(v[7:0]) == 1)
                     && ((v[7:0] & ~DSC_MODE_MAP) == 8'h00);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode. Every access completes in its second access cycle, after one wait state.
    logic       acc;
    logic       wr;
    logic       rd;
    logic       hit_mode, hit_map, hit_ovr, hit_rcl, hit_sto, hit_acl, hit_ctl, hit_st;
    logic       busy;
    logic       mapped;
    logic       wr_err;

    assign acc      = psel & penable & ~pready;
    assign hit_mode = paddr == byte_addr(DSC_IDX_MODE);
    assign hit_map  = paddr == byte_addr(DSC_IDX_MODE_MAP);
    assign hit_ovr  = paddr == byte_addr(DSC_IDX_OVR);
    assign hit_rcl  = paddr == byte_addr(DSC_IDX_RECALL);
    assign hit_sto  = paddr == byte_addr(DSC_IDX_STORE);
    assign hit_acl  = paddr == byte_addr(DSC_IDX_AUTOCAL);
    assign hit_ctl  = paddr == byte_addr(DSC_IDX_CTRL);
    assign hit_st   = paddr == byte_addr(DSC_IDX_STATUS);
    assign mapped   = hit_mode | hit_map | hit_ovr | hit_rcl | hit_sto | hit_acl | hit_ctl | hit_st;

    // Writes to read-only words, bad modes and calibration commands while busy are errors.
    assign wr_err = ~mapped | hit_map | hit_ovr | hit_st
                  | (hit_mode & ~one_hot_ok(pwdata))
                  | ((hit_rcl | hit_sto | hit_acl) & busy)
                  | ((hit_rcl | hit_sto) & (pwdata >= 32'(SETS)))
                  | (hit_sto & pwdata[7:0] == DSC_SET_FACTORY & USER_SETS > 0);
    assign wr = acc & pwrite & ~wr_err;
    assign rd = acc & ~pwrite;

    ////////////////////////////////////////////////////////////////////////////////
    // Acquisition run flag and sticky overrange flags.
    logic       run_q;
    logic [1:0] ovr_q;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            run_q <= 1'b0;
        end else if (acq_start) begin
            run_q <= 1'b1;
        end else if (wr & hit_ctl) begin
            run_q <= pwdata[DSC_CTRL_RUN];
        end
    end

    // Each channel's flag is set by its own input only; a start reloads both from the inputs.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ovr_q <= 2'b00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (acq_start) begin
                    ovr_q[c] <= ovr_in[c];
                end else if (ovr_in[c]) begin
                    ovr_q[c] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Operating mode and the mode-derived datapath controls.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_q          <= DSC_MODE_RESET;
            stream_en_q     <= 1'b0;
            dual_rate_en_q  <= 1'b0;
            seg_fixed_len_q <= 1'b0;
        end else if (wr & hit_mode) begin
            mode_q          <= pwdata[7:0];
            stream_en_q     <= |(pwdata[7:0] & DSC_MODE_STREAM_MSK);
            dual_rate_en_q  <= |(pwdata[7:0] & DSC_MODE_DUAL_MSK);
            seg_fixed_len_q <= |(pwdata[7:0] & DSC_MODE_SEG_MSK);
        end
    end

    logic mode_err_q;
    logic store_err_q;

    // A rejected mode or store write sets its error flag; a good write of the same kind clears it.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_err_q  <= 1'b0;
            store_err_q <= 1'b0;
        end else begin
            if (acc & pwrite & hit_mode) begin
                mode_err_q <= wr_err;
            end
            if (acc & pwrite & hit_sto) begin
                store_err_q <= wr_err;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Calibration sequencer.
    dsc_state_t       state_q;
    logic [SET_W-1:0] set_q;
    logic [7:0]       last_recall_q;
    logic [7:0]       last_store_q;
    logic             all_rng_q;
    logic [15:0]      acl_cnt_q;
    logic             st_wr, st_rd, st_done;
    logic [DSC_CAL_W-1:0] st_rdata;

    assign busy  = state_q != DSC_IDLE;
    assign st_rd = (state_q == DSC_BOOT || state_q == DSC_RECALL) & ~st_done;
    assign st_wr = (state_q == DSC_STORE) & ~st_done;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= DSC_BOOT;
            set_q   <= '0;
        end else begin
            case (state_q)
                DSC_IDLE: begin
                    if (wr & hit_rcl) begin
                        state_q <= DSC_RECALL;
                        set_q   <= pwdata[SET_W-1:0];
                    end else if (wr & hit_sto) begin
                        state_q <= DSC_STORE;
                        set_q   <= pwdata[SET_W-1:0];
                    end else if (wr & hit_acl) begin
                        state_q <= DSC_AUTOCAL;
                    end
                end
                DSC_BOOT, DSC_RECALL, DSC_STORE: begin
                    if (st_done) begin
                        state_q <= DSC_IDLE;
                    end
                end
                DSC_AUTOCAL: begin
                    if (acl_cnt_q == 16'(AUTOCAL_CYC - 1)) begin
                        state_q <= DSC_IDLE;
                    end
                end
                default: state_q <= DSC_IDLE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            acl_cnt_q <= 16'h0000;
            all_rng_q <= 1'b0;
        end else if (state_q == DSC_AUTOCAL) begin
            acl_cnt_q <= acl_cnt_q + 16'h0001;
        end else begin
            acl_cnt_q <= 16'h0000;
            if (wr & hit_acl & ~busy) begin
                all_rng_q <= pwdata == DSC_ALL_RANGES;
            end
        end
    end

    // Autocal only nudges the working word; storage is untouched until a store.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cal_work_q <= DSC_CAL_RESET;
        end else if ((state_q == DSC_BOOT || state_q == DSC_RECALL) && st_done) begin
            cal_work_q <= st_rdata;
        end else if (state_q == DSC_AUTOCAL && acl_cnt_q == 16'(AUTOCAL_CYC - 1)) begin
            cal_work_q <= cal_work_q + (all_rng_q ? DSC_CAL_W'(2) : DSC_CAL_W'(1));
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_recall_q <= DSC_SET_FACTORY;
            last_store_q  <= DSC_SET_FACTORY;
        end else if (st_done) begin
            if (state_q == DSC_STORE) begin
                last_store_q <= 8'(set_q);
            end else begin
                last_recall_q <= 8'(set_q);
            end
        end
    end

    dsc_cal_store #(
        .SETS  (SETS),
        .CAL_W (DSC_CAL_W)
    ) u_store (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .wr_en   (st_wr),
        .rd_en   (st_rd),
        .set_idx (set_q),
        .wr_data (cal_work_q),
        .rd_data (st_rdata),
        .done    (st_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux and APB response.
    logic [31:0] rdata_d;
    logic [31:0] status_w;

    assign status_w = {26'h000_0000, all_rng_q, stream_en_q, run_q, store_err_q, mode_err_q, busy};

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (1'b1)
            hit_mode: rdata_d = {24'h00_0000, mode_q};
            hit_map:  rdata_d = {24'h00_0000, DSC_MODE_MAP};
            hit_ovr:  rdata_d = {30'h0000_0000, ovr_q};
            hit_rcl:  rdata_d = {24'h00_0000, last_recall_q};
            hit_sto:  rdata_d = {24'h00_0000, last_store_q};
            hit_ctl:  rdata_d = {31'h0000_0000, run_q};
            hit_st:   rdata_d = status_w;
            default:  rdata_d = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= acc & ((pwrite & wr_err) | (~pwrite & (~mapped | hit_acl)));
            if (rd) begin
                prdata <= rdata_d;
            end
        end
    end

endmodule // dsc_regs

// ===== dsc_regs_monitor.sv
// Checker for the register bank: APB answer timing and the mode outputs.
// Assumes it is bound to dsc_regs and sees only that module's ports.
`timescale 1ns/1ps

module dsc_regs_monitor #(
    parameter int USER_SETS   = 3,
    parameter int AUTOCAL_CYC = 16
) (
    input wire logic                           ref_clk,
    input wire logic                           rst_b,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [dsc_pkg::DSC_ADDR_W-1:0] paddr,
    input wire logic [31:0]                    pwdata,
    input wire logic [31:0]                    prdata,
    input wire logic                           pready,
    input wire logic                           pslverr,
    input wire logic [1:0]                     ovr_in,
    input wire logic                           acq_start,
    input wire logic [7:0]                     mode_q,
    input wire logic                           stream_en_q,
    input wire logic                           dual_rate_en_q,
    input wire logic                           seg_fixed_len_q,
    input wire logic [dsc_pkg::DSC_CAL_W-1:0]  cal_work_q
);
    import dsc_pkg::*;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    wire wr_acc = psel && penable && pwrite;

    sequence setup_s; psel && !penable; endsequence
    sequence access_s; psel && penable; endsequence

    ////////////////////////////////////////////////////////////
    a_ready_latency: assert property (setup_s ##1 access_s |=> pready)
        else $error("pready late after access phase");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without a request");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_mode_onehot: assert property ($onehot(mode_q))
        else $error("mode not one-hot");
    a_mode_legal: assert property ((mode_q & ~DSC_MODE_MAP) == 8'h00)
        else $error("unsupported mode held");
    a_stream_flag: assert property ($stable(mode_q) |-> stream_en_q == (|(mode_q & 8'hf0)))
        else $error("stream flag wrong");
    a_dual_seg: assert property ($stable(mode_q) |-> dual_rate_en_q == (|(mode_q & 8'h88))
        && seg_fixed_len_q == (|(mode_q & 8'h22)))
        else $error("dual rate or segment flag wrong");
    a_mode_cause: assert property ($changed(mode_q) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("mode changed without a write");
    a_err_keeps_mode: assert property (pslverr |=> mode_q == $past(mode_q, 3))
        else $error("refused access changed mode");
endmodule // dsc_regs_monitor

// ===== dsc_front_end.sv
// Front-end model: starts a run and shows single-sample overrange excursions.
// Assumes the bench calls run() between APB transfers, never alongside one.
`timescale 1ns/1ps

module dsc_front_end (
    input  wire logic       ref_clk,
    output logic      [1:0] ovr_in,
    output logic            acq_start
);
    initial begin
        ovr_in    = 2'b00;
        acq_start = 1'b0;
    end

    // One sample only, the shortest excursion the flags must still catch.
    task automatic run(input logic [1:0] hits);
        @(posedge ref_clk);
        acq_start <= 1'b1;
        @(posedge ref_clk);
        acq_start <= 1'b0;
        repeat (3) @(posedge ref_clk);
        ovr_in <= hits;
        @(posedge ref_clk);
        ovr_in <= 2'b00;
    endtask
endmodule // dsc_front_end

// ===== test_digitizer_status_calib_mode_regs.sv
// Self-checking bench for the register bank, driven over APB.
// Assumes the package, the design, the front-end model and the monitor are compiled first.
`timescale 1ns/1ps

module test_digitizer_status_calib_mode_regs;
    import dsc_pkg::*;
    logic                  ref_clk = 1'b0;
    logic                  rst_b, psel, penable, pwrite, pready, pslverr, acq_start;
    logic                  stream_en_q, dual_rate_en_q, seg_fixed_len_q;
    logic [DSC_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata, prdata;
    logic [1:0]            ovr_in;
    logic [7:0]            mode_q;
    logic [DSC_CAL_W-1:0]  cal_work_q;
    int                    err_total = 0;
    int                    n_checks = 0;
    logic [7:0]            modes[6] = '{8'h01, 8'h02, 8'h08, 8'h10, 8'h20, 8'h80};
    logic [7:0]            bad[5] = '{8'h00, 8'h03, 8'h04, 8'h40, 8'h81};

    always #2.5 ref_clk = ~ref_clk;

    dsc_regs uut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ovr_in(ovr_in), .acq_start(acq_start), .mode_q(mode_q), .stream_en_q(stream_en_q),
        .dual_rate_en_q(dual_rate_en_q), .seg_fixed_len_q(seg_fixed_len_q), .cal_work_q(cal_work_q));
    dsc_front_end fe (.ref_clk(ref_clk), .ovr_in(ovr_in), .acq_start(acq_start));

    ////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, x, s);
        end
    endtask

    // The answer is taken at the rising edge that samples pready high, and only then is the request released.
    task automatic apb(input logic w, input logic [31:0] idx, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n = 0;
        @(posedge ref_clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {idx[15:0], 2'b00};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) err_total++;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk("wr pslverr", 32'(e), 32'(xe));
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk("rd pslverr", 32'(e), 32'(xe));
        if (!xe) chk("prdata", r, x);
    endtask

    task automatic idle();
        logic [31:0] r;
        logic e;
        int n = 0;
        do begin
            apb(1'b0, DSC_IDX_STATUS, 32'h0000_0000, r, e);
            n++;
        end while (r[DSC_ST_BUSY] !== 1'b0 && n < 40);
        chk("busy", 32'(r[DSC_ST_BUSY]), 32'h0000_0000);
    endtask

    // The word is read only once the run bit has been cleared.
    task automatic ovr(input logic [1:0] hits);
        fe.run(hits);
        wr(DSC_IDX_CTRL, 32'h0000_0000, 1'b0);
        rd(DSC_IDX_OVR, 32'(hits), 1'b0);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        report_and_stop();
    end

    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        idle();
        rd(DSC_IDX_RECALL, 32'h0000_0000, 1'b0);
        chk("cal_work_q", 32'(cal_work_q), 32'h0000_0000);
        rd(DSC_IDX_MODE, 32'h0000_0001, 1'b0);
        rd(DSC_IDX_MODE_MAP, 32'h0000_00bb, 1'b0);
        foreach (modes[i]) begin
            wr(DSC_IDX_MODE, 32'(modes[i]), 1'b0);
            rd(DSC_IDX_MODE, 32'(modes[i]), 1'b0);
            chk("flags", 32'({stream_en_q, dual_rate_en_q, seg_fixed_len_q}),
                32'({i > 2, i % 3 == 2, i % 3 == 1}));
        end
        foreach (bad[i]) wr(DSC_IDX_MODE, 32'(bad[i]), 1'b1);
        rd(DSC_IDX_MODE, 32'h0000_0080, 1'b0);
        rd(DSC_IDX_STATUS, 32'h0000_0012, 1'b0);
        wr(DSC_IDX_MODE_MAP, 32'h0000_0001, 1'b1);
        wr(DSC_IDX_OVR, 32'h0000_0000, 1'b1);
        rd(DSC_IDX_AUTOCAL, 32'h0000_0000, 1'b1);
        rd(32'h0000_0100, 32'h0000_0000, 1'b1);
        ovr(2'b01);
        ovr(2'b10);
        ovr(2'b11);
        ovr(2'b00);
        wr(DSC_IDX_AUTOCAL, DSC_ALL_RANGES, 1'b0);
        idle();
        chk("cal_work_q", 32'(cal_work_q), 32'h0000_0002);
        wr(DSC_IDX_AUTOCAL, 32'h0000_0001, 1'b0);
        wr(DSC_IDX_RECALL, 32'h0000_0001, 1'b1);
        idle();
        chk("cal_work_q", 32'(cal_work_q), 32'h0000_0003);
        wr(DSC_IDX_STORE, 32'h0000_0000, 1'b1);
        wr(DSC_IDX_STORE, 32'h0000_0002, 1'b0);
        idle();
        rd(DSC_IDX_STORE, 32'h0000_0002, 1'b0);
        wr(DSC_IDX_AUTOCAL, DSC_ALL_RANGES, 1'b0);
        idle();
        chk("cal_work_q", 32'(cal_work_q), 32'h0000_0005);
        wr(DSC_IDX_RECALL, 32'h0000_0001, 1'b0);
        idle();
        chk("cal_work_q", 32'(cal_work_q), 32'h0000_0000);
        rd(DSC_IDX_RECALL, 32'h0000_0001, 1'b0);
        wr(DSC_IDX_RECALL, 32'h0000_0002, 1'b0);
        idle();
        chk("cal_work_q", 32'(cal_work_q), 32'h0000_0003);
        wr(DSC_IDX_RECALL, 32'h0000_0004, 1'b1);
        wr(DSC_IDX_RECALL, 32'h0000_0000, 1'b0);
        idle();
        rd(DSC_IDX_RECALL, 32'h0000_0000, 1'b0);
        report_and_stop();
    end
endmodule // test_digitizer_status_calib_mode_regs

bind dsc_regs dsc_regs_monitor #(.USER_SETS(USER_SETS), .AUTOCAL_CYC(AUTOCAL_CYC)) u_mon (
    .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ovr_in(ovr_in), .acq_start(acq_start), .mode_q(mode_q), .stream_en_q(stream_en_q),
    .dual_rate_en_q(dual_rate_en_q), .seg_fixed_len_q(seg_fixed_len_q), .cal_work_q(cal_work_q));
